// *** verilog/pfg_top.sv ***
/*
 * Four-group PWM generator: shared counter, alignment and update control,
 * holding duty registers and four group comparators.
 * Assumes the host drives the plain control ports synchronous to clk_sys.
 */
`timescale 1ns/10ps
module pfg_top #(
	parameter int NUM_GROUPS = 4
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [15:0] period,
	input wire logic center_align,
	input wire logic double_update,
	input wire logic [3:0] paired_mode,
	input wire logic duty_wr,
	input wire logic [3:0] duty_sel,
	input wire logic [15:0] duty_wdata,
	output logic [15:0] pwm_out,
	output logic period_start,
	output logic [15:0] count_out
);
	// elaboration check: the group fabric is fixed at four
	generate
		if (NUM_GROUPS != pfg_pkg::GROUPS) begin : g_bad_groups
			$error("pfg_top serves exactly four groups");
		end
	endgenerate

	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	pfg_pkg::pfg_phase_t phase_r;
	pfg_pkg::pfg_phase_t phase_nxt;
	logic top_r;
	logic top_nxt;
	logic mid_r;
	logic mid_nxt;
	logic [15:0] hold_r [16];
	logic [15:0] hold_nxt [16];
	logic [15:0] pwm_w;
	logic [15:0] pwm_out_nxt;
	logic period_start_nxt;
	logic [15:0] count_out_nxt;

	// counter: up/down for center, up-and-wrap for edge alignment
	always_comb begin
		cnt_nxt = cnt_r;
		phase_nxt = phase_r;
		top_nxt = 1'b0;
		mid_nxt = 1'b0;
		unique case (phase_r)
			pfg_pkg::PFG_UP: begin
				if (cnt_r + 16'h0001 >= period) begin
					if (center_align) begin
						phase_nxt = pfg_pkg::PFG_DOWN;
						cnt_nxt = cnt_r;
						mid_nxt = 1'b1;
					end else begin
						cnt_nxt = pfg_pkg::CNT_RST;
						top_nxt = 1'b1;
					end
				end else begin
					cnt_nxt = cnt_r + 16'h0001;
				end
			end
			pfg_pkg::PFG_DOWN: begin
				if (cnt_r == 16'h0000) begin
					phase_nxt = pfg_pkg::PFG_UP;
					top_nxt = 1'b1;
				end else begin
					cnt_nxt = cnt_r - 16'h0001;
				end
			end
			default: begin
				phase_nxt = pfg_pkg::PFG_UP;
				cnt_nxt = pfg_pkg::CNT_RST;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_r <= pfg_pkg::CNT_RST;
			phase_r <= pfg_pkg::PFG_UP;
			top_r <= 1'b0;
			mid_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			phase_r <= phase_nxt;
			top_r <= top_nxt;
			mid_r <= mid_nxt;
		end
	end

	// holding registers take software writes at any time
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			hold_nxt[i] = hold_r[i];
		end
		if (duty_wr) begin
			hold_nxt[duty_sel] = duty_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < 16; i++) begin
			if (rst) begin
				hold_r[i] <= pfg_pkg::DUTY_RST;
			end else begin
				hold_r[i] <= hold_nxt[i];
			end
		end
	end

	generate
		for (genvar g = 0; g < pfg_pkg::GROUPS; g++) begin : g_grp
			pfg_group_if gif ();
			assign gif.count = cnt_r;
			// load on the strobes' next values: the new duty is then in force
			// from the first cycle of its half, keeping each half symmetric
			assign gif.load_top = top_nxt;
			assign gif.load_mid = mid_nxt;
			assign gif.center = center_align;
			// update scheme only in center mode
			assign gif.double_upd = double_update & center_align;
			assign gif.paired = paired_mode[g];
			assign gif.duty_hold = {hold_r[4*g+3], hold_r[4*g+2], hold_r[4*g+1], hold_r[4*g]};
			assign pwm_w[4*g +: 4] = gif.pwm;
			pfg_group u_grp (
				.clk_sys(clk_sys),
				.rst(rst),
				.gi(gif)
			);
		end
	endgenerate

	// output next values: everything leaving the block is registered
	always_comb begin
		pwm_out_nxt = pwm_w;
		period_start_nxt = top_r;
		count_out_nxt = cnt_r;
	end

	// registered outputs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pwm_out <= pfg_pkg::OUT_RST;
			period_start <= 1'b0;
			count_out <= pfg_pkg::CNT_RST;
		end else begin
			pwm_out <= pwm_out_nxt;
			period_start <= period_start_nxt;
			count_out <= count_out_nxt;
		end
	end

	edge_up_a: assert property (@(posedge clk_sys) disable iff (rst)
		!center_align && phase_r == pfg_pkg::PFG_UP && !top_nxt
		|=> cnt_r == $past(cnt_r) + 16'h0001)
		else $error("edge mode counter did not step up");
	mid_center_a: assert property (@(posedge clk_sys) disable iff (rst)
		mid_r |-> phase_r == pfg_pkg::PFG_DOWN)
		else $error("midpoint strobe outside down phase");
	// period start follows down phase end
	top_after_a: assert property (@(posedge clk_sys) disable iff (rst)
		phase_r == pfg_pkg::PFG_DOWN && cnt_r == 16'h0000 |=> top_r ##1 period_start)
		else $error("period start not flagged");
	hold_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
		duty_wr |=> hold_r[$past(duty_sel)] == $past(duty_wdata))
		else $error("holding write lost");
	out_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
		1'b1 |=> pwm_out == $past(pwm_w))
		else $error("outputs did not follow the group comparators");
	count_mirror_a: assert property (@(posedge clk_sys) disable iff (rst)
		1'b1 |=> count_out == $past(cnt_r))
		else $error("counter output not one cycle behind");
	phase_onehot_a: assert property (@(posedge clk_sys) disable iff (rst)
		$onehot(phase_r))
		else $error("counter phase lost its one-hot code");
	top_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
		top_r |-> cnt_r == pfg_pkg::CNT_RST)
		else $error("period start away from counter zero");
	start_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
		period_start && period >= 16'h0002 |=> !period_start)
		else $error("period start longer than one cycle");
	mid_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		mid_r |-> cnt_r == $past(cnt_r))
		else $error("counter moved at the midpoint");
	mid_center_only_a: assert property (@(posedge clk_sys) disable iff (rst)
		mid_r |-> $past(center_align))
		else $error("midpoint strobe without center alignment");
	hold_own_a: assert property (@(posedge clk_sys) disable iff (rst)
		duty_wr |=> hold_r[$past(duty_sel) ^ 4'h1] == $past(hold_r[duty_sel ^ 4'h1]))
		else $error("write disturbed a neighbouring holding register");
	hold_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
		!duty_wr |=> hold_r[5] == $past(hold_r[5]))
		else $error("holding register changed without a write");
	center_c: cover property (@(posedge clk_sys) center_align && mid_r);
	dbl_mid_c: cover property (@(posedge clk_sys) mid_r && double_update && center_align);
	edge_c: cover property (@(posedge clk_sys) !center_align && top_r);
endmodule

// *** verilog/pfg_pkg.sv ***
/*
 * Shared constants and types for the four-group PWM generator.
 * Assumes a single 40 MHz system clock and a synchronous active-high reset.
 */
package pfg_pkg;
	localparam int GROUPS = 4;
	localparam int OUTS_PER_GROUP = 4;
	localparam int CNT_W = 16;
	localparam int CH_TOTAL = 16;
	localparam logic [15:0] PERIOD_RST = 16'h0100;
	localparam logic [15:0] DUTY_RST = 16'h0000;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [1:0] CH_ALL_ZERO = 2'h0;
	localparam logic PAIRED_RST = 1'b1;
	localparam logic CENTER_RST = 1'b1;
	localparam logic DOUBLE_RST = 1'b0;
	localparam logic [15:0] OUT_RST = 16'h0000;

	// counter phase, one-hot
	typedef enum logic [1:0] {
		PFG_UP = 2'b01,
		PFG_DOWN = 2'b10
	} pfg_phase_t;
endpackage

// *** verilog/pfg_group_if.sv ***
/*
 * Bundle between the timebase/top and one group comparator.
 * Assumes the shared counter and load strobes come from the top module.
 */
`timescale 1ns/10ps
interface pfg_group_if;
	logic [15:0] count;
	logic load_top;
	logic load_mid;
	logic center;
	logic double_upd;
	logic paired;
	logic [63:0] duty_hold;
	logic [3:0] pwm;

	modport gen (output count, output load_top, output load_mid, output center,
		output double_upd, output paired, output duty_hold, input pwm);
	modport grp (input count, input load_top, input load_mid, input center,
		input double_upd, input paired, input duty_hold, output pwm);
endinterface

// *** verilog/pfg_group.sv ***
/*
 * One group of four outputs: active duty registers loaded from holding values
 * at the permitted instants, then compared against the shared counter.
 * Assumes the top module supplies the counter and load strobes.
 */
`timescale 1ns/10ps
module pfg_group (
	input wire logic clk_sys,
	input wire logic rst,
	pfg_group_if.grp gi
);
	logic [15:0] duty_r [4];
	logic [15:0] duty_nxt [4];
	logic [3:0] pwm_r;
	logic [3:0] pwm_nxt;
	logic [3:0] raw;

	// duty reload: top of period always, midpoint only in double update
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			duty_nxt[i] = duty_r[i];
			if (gi.load_top || (gi.load_mid && gi.center && gi.double_upd)) begin
				duty_nxt[i] = gi.duty_hold[16*i +: 16];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < 4; i++) begin
			if (rst) begin
				duty_r[i] <= pfg_pkg::DUTY_RST;
			end else begin
				duty_r[i] <= duty_nxt[i];
			end
		end
	end

	// compare: output high while count below duty
	generate
		for (genvar i = 0; i < 4; i++) begin : g_cmp
			assign raw[i] = (gi.count < duty_r[i]);
		end
	endgenerate

	// pairing: odd output complements even one in paired mode
	always_comb begin
		pwm_nxt = raw;
		if (gi.paired) begin
			pwm_nxt[1] = ~raw[0];
			pwm_nxt[3] = ~raw[2];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pwm_r <= 4'h0;
		end else begin
			pwm_r <= pwm_nxt;
		end
	end

	assign gi.pwm = pwm_r;

	paired_compl_a: assert property (@(posedge clk_sys) disable iff (rst)
		$past(gi.paired) && !$past(rst) |-> (gi.pwm[1] == ~gi.pwm[0]))
		else $error("paired outputs not complementary");
	// midpoint load blocked in single update
	single_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		gi.load_mid && !gi.double_upd |=> $stable(duty_r[0]))
		else $error("duty changed at midpoint in single update");
	double_load_a: assert property (@(posedge clk_sys) disable iff (rst)
		gi.load_mid && gi.double_upd && gi.center |=> duty_r[0] == $past(gi.duty_hold[15:0]))
		else $error("duty not loaded at midpoint");
	hold_stable_a: assert property (@(posedge clk_sys) disable iff (rst)
		!gi.load_top && !gi.load_mid |=> $stable(duty_r[2]))
		else $error("active duty changed outside update instant");
	indep_out_a: assert property (@(posedge clk_sys) disable iff (rst)
		!gi.paired |=> gi.pwm[1] == $past(raw[1]))
		else $error("nonpaired output not independent");
	mid_load_c: cover property (@(posedge clk_sys) gi.load_mid && gi.double_upd);
	paired_c: cover property (@(posedge clk_sys) gi.paired && gi.pwm[0]);
endmodule

// *** tb/pfg_stage_model.sv ***
/*
 * Power stage model: counts on-cycles of each output over one period.
 * Assumes period_start pulses once per period and pwm is registered.
 */
`timescale 1ns/10ps
module pfg_stage_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [15:0] pwm,
	input wire logic period_start,
	output logic [15:0] hi_last [16]
);
	logic [15:0] hi_acc [16];

	// accumulate on-time, snapshot at each period start
	always @(posedge clk_sys) begin
		for (int i = 0; i < 16; i++) begin
			if (rst) begin
				hi_acc[i] <= 16'h0000;
				hi_last[i] <= 16'h0000;
			end else if (period_start) begin
				hi_last[i] <= hi_acc[i];
				hi_acc[i] <= {15'h0000, pwm[i]};
			end else begin
				hi_acc[i] <= hi_acc[i] + {15'h0000, pwm[i]};
			end
		end
	end
endmodule

// *** tb/pfg_top_tb_top.sv ***
/*
 * Self-checking bench for the four-group PWM generator.
 * Assumes period input 8 (8 cycles edge, 16 cycles center) and the power stage model on all outputs.
 */
`timescale 1ns/10ps
module pfg_top_tb_top;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [15:0] period = 16'h0008;
	logic center_align = 1'b0;
	logic double_update = 1'b0;
	logic [3:0] paired_mode = 4'h0;
	logic duty_wr = 1'b0;
	logic [3:0] duty_sel = 4'h0;
	logic [15:0] duty_wdata = 16'h0000;
	logic [15:0] pwm_out;
	logic period_start;
	logic [15:0] count_out;
	logic [15:0] hi_last [16];
	int error_cnt = 0;
	int compares = 0;

	always #12.5 clk_sys = ~clk_sys;

	pfg_top #(.NUM_GROUPS(4)) dut (.clk_sys(clk_sys), .rst(rst), .period(period),
		.center_align(center_align), .double_update(double_update),
		.paired_mode(paired_mode), .duty_wr(duty_wr), .duty_sel(duty_sel),
		.duty_wdata(duty_wdata), .pwm_out(pwm_out), .period_start(period_start),
		.count_out(count_out));

	pfg_stage_model stage (.clk_sys(clk_sys), .rst(rst), .pwm(pwm_out),
		.period_start(period_start), .hi_last(hi_last));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] sel, input logic [15:0] d);
		@(posedge clk_sys);
		duty_wr <= 1'b1;
		duty_sel <= sel;
		duty_wdata <= d;
		@(posedge clk_sys);
		duty_wr <= 1'b0;
	endtask

	task automatic wait_ps;
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (period_start !== 1'b1 && n < 300);
		chk({15'h0000, period_start}, 16'h0001);
	endtask

	// program all duties, settle, compare on-time of every output
	task automatic run_all(input logic ctr, input logic [3:0] pm);
		int e;
		int jj;
		@(posedge clk_sys);
		center_align <= ctr;
		paired_mode <= pm;
		double_update <= 1'b0;
		for (int k = 0; k < 16; k++) wr(4'(k), 16'(k % 9));
		repeat (4) wait_ps;
		@(posedge clk_sys);
		#1;
		for (int k = 0; k < 16; k++) begin
			e = (pm[k / 4] && k % 2) ? 8 - ((k - 1) % 9) : k % 9;
			chk(hi_last[k], 16'(ctr ? 2 * e : e));
		end
		// counter walk: top cycle was two edges before the snapshot edge
		for (int i = 0; i < 16; i++) begin
			#25;
			jj = (i + 2) % (ctr ? 16 : 8);
			chk(count_out, 16'(jj < 8 ? jj : 15 - jj));
			if (pm == 4'hF) chk(pwm_out & 16'hAAAA, ~(pwm_out << 1) & 16'hAAAA);
		end
	endtask

	task automatic t_edge;
		run_all(1'b0, 4'h0);
		$display("test edge done");
	endtask

	task automatic t_center;
		run_all(1'b1, 4'h0);
		$display("test center done");
	endtask

	task automatic t_paired;
		run_all(1'b1, 4'hF);
		$display("test paired done");
	endtask

	// duty 3 written early, 6 written late each period on output 5
	task automatic t_upd(input logic dbl);
		@(posedge clk_sys);
		center_align <= 1'b1;
		paired_mode <= 4'h0;
		double_update <= dbl;
		repeat (6) begin
			wait_ps;
			wr(4'h5, 16'h0003);
			repeat (8) @(posedge clk_sys);
			wr(4'h5, 16'h0006);
		end
		chk(hi_last[5], dbl ? 16'h0009 : 16'h000C);
		$display("test update %0d done", dbl);
	endtask

	task automatic test_done;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// watchdog sized well above the full sequence
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		test_done;
	end

	initial begin
		repeat (7) @(posedge clk_sys);
		#1;
		chk(pwm_out, 16'h0000);
		chk(count_out, 16'h0000);
		@(posedge clk_sys);
		rst <= 1'b0;
		t_edge;
		t_center;
		t_paired;
		t_upd(1'b0);
		t_upd(1'b1);
		test_done;
	end
endmodule
